//--- hdl/tsi_pkg.sv
// package for the three source interrupt unit: register map, fields, reset values
package tsi_pkg;
  // byte addresses on the register bus
  localparam logic [7:0] TSI_INTERRUPT_CONTROL_IDX = 8'h0b;
  localparam logic [11:0] TSI_ADDR_INTERRUPT_CONTROL = {2'h0, TSI_INTERRUPT_CONTROL_IDX, 2'h0};
  localparam logic [11:0] TSI_ADDR_EPST = 12'h06c;
  localparam logic [11:0] TSI_ADDR_LINK = 12'h068;
  localparam logic [11:0] TSI_ADDR_STAT = 12'h100;
  // interrupt_control fields
  localparam int TSI_BIT_MASTER = 0;
  localparam int TSI_BIT_USB_EN = 1;
  localparam int TSI_BIT_T0_EN = 2;
  localparam int TSI_BIT_T1_EN = 3;
  localparam int TSI_BIT_USB_F = 4;
  localparam int TSI_BIT_T0_F = 5;
  localparam int TSI_BIT_T1_F = 6;
  // usb_link_status_control fields
  localparam int TSI_BIT_SUSPEND = 0;
  localparam int TSI_BIT_RESUME = 3;
  localparam logic [7:0] TSI_INTERRUPT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TSI_INTERRUPT_CONTROL_MASK = 8'h7f;
  localparam logic [7:0] TSI_LINK_MASK = 8'h09;
  localparam logic [2:0] TSI_EP_MASK = 3'h7;
  // call vectors
  localparam logic [11:0] TSI_VEC_USB = 12'h004;
  localparam logic [11:0] TSI_VEC_T0 = 12'h008;
  localparam logic [11:0] TSI_VEC_T1 = 12'h00c;
  localparam logic [3:0] TSI_STACK_DEPTH = 4'h8;

  typedef struct packed {
    logic suspend;
    logic resume;
    logic bus_reset;
    logic [2:0] ep_access;
  } tsi_usb_ev_type;

  typedef struct packed {
    logic req;
    logic [11:0] vector;
    logic [1:0] source;
  } tsi_call_type;

  typedef enum logic [1:0] {TSI_SRC_NONE, TSI_SRC_USB, TSI_SRC_T0, TSI_SRC_T1} tsi_src_type;
endpackage : tsi_pkg

//--- hdl/tsi_irq_unit.sv
// three source interrupt unit with AHB-Lite register slave
// What this block does
// - accepting any interrupt clears master enable
// - flags still set while master disabled
// - software re-enable inside routine allows nesting
// - no acknowledge while stack full; hold request
// - push only program counter, branch to vector
// - four usb events set usb flag
// - usb call to 04H clears flag, master
// - endpoint access sets endpoint status bit
// - suspend sets link bit 0, usb interrupt
// - resume sets link bit 3, usb interrupt
// - bus reset raises usb interrupt
// - timer0 overflow sets bit 5, vector 08H
// - timer1 overflow sets bit 6, vector 0CH
// - withhold acknowledges until return or re-enable
// - interrupt return sets master; plain return not
// - bits 0-3 are active-high enables
// - bit 7 always reads zero
// - sample requests at phase two pulse
// - fixed priority usb, timer0, timer1
// - flags stay set until serviced or cleared
// - every source can wake halted device
// - held request served after stack pops
// - flag already set at halt blocks wake
`timescale 1ns/1ps
module tsi_irq_unit
  import tsi_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic PHASE_TWO_PULSE,
  input wire logic TIMER0_OVERFLOW,
  input wire logic TIMER1_OVERFLOW,
  input wire tsi_usb_ev_type USB_EVENTS,
  input wire logic STACK_FULL,
  input wire logic RETURN_FROM_INTERRUPT,
  input wire logic HALT_ENTER,
  input wire logic HALTED,
  input wire logic CALL_TAKEN,
  output tsi_call_type CALL_REQ,
  output logic WAKE_UP
);

  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  // ahb-lite address phase capture
  logic wr_pend_q;
  logic wr_pend_d;
  logic [11:0] addr_q;
  logic [11:0] addr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic addr_phase;

  // interrupt state
  logic [7:0] interrupt_control_q;
  logic [7:0] interrupt_control_d;
  logic [2:0] ep_q;
  logic [2:0] ep_d;
  logic [7:0] link_q;
  logic [7:0] link_d;
  logic [2:0] latched_q;
  logic [2:0] latched_d;
  logic [2:0] halt_block_q;
  logic [2:0] halt_block_d;
  tsi_call_type call_q;
  tsi_call_type call_d;
  logic wake_q;
  logic wake_d;

  logic [2:0] hw_set;
  logic [2:0] pending;
  logic usb_event;
  logic wr_interrupt_control;
  logic wr_ep;
  logic wr_link;
  logic [7:0] wbyte;

  assign addr_phase = HSEL && HREADY && HTRANS[1];
  assign wbyte = HWDATA[7:0];
  assign wr_interrupt_control = wr_pend_q && hit(addr_q, TSI_ADDR_INTERRUPT_CONTROL);
  assign wr_ep = wr_pend_q && hit(addr_q, TSI_ADDR_EPST);
  assign wr_link = wr_pend_q && hit(addr_q, TSI_ADDR_LINK);

  assign usb_event = USB_EVENTS.suspend || USB_EVENTS.resume || USB_EVENTS.bus_reset
    || (|USB_EVENTS.ep_access);
  assign hw_set = {TIMER1_OVERFLOW, TIMER0_OVERFLOW, usb_event};

  always_comb begin
    wr_pend_d = addr_phase && HWRITE;
    addr_d = addr_phase ? HADDR[11:0] : addr_q;
    rdata_d = rdata_q;
    if (addr_phase && !HWRITE) begin
      unique case (1'b1)
        hit(HADDR[11:0], TSI_ADDR_INTERRUPT_CONTROL): rdata_d = {24'h000000, interrupt_control_q};
        hit(HADDR[11:0], TSI_ADDR_EPST): rdata_d = {29'h00000000, ep_q};
        hit(HADDR[11:0], TSI_ADDR_LINK): rdata_d = {24'h000000, link_q};
        hit(HADDR[11:0], TSI_ADDR_STAT): rdata_d = {27'h0000000, halt_block_q, call_q.req, wake_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    interrupt_control_d = interrupt_control_q;
    ep_d = ep_q;
    link_d = link_q;
    latched_d = latched_q;
    halt_block_d = halt_block_q;
    call_d = call_q;
    wake_d = 1'b0;
    pending = 3'h0;
    if (wr_interrupt_control) begin
      interrupt_control_d = wbyte & TSI_INTERRUPT_CONTROL_MASK;
    end
    if (wr_ep) begin
      ep_d = wbyte[2:0] & TSI_EP_MASK;
    end
    if (wr_link) begin
      link_d = wbyte & TSI_LINK_MASK;
    end
    if (RETURN_FROM_INTERRUPT) begin
      interrupt_control_d[TSI_BIT_MASTER] = 1'b1;
    end
    latched_d = latched_q | hw_set;
    // flags set regardless of master, set wins
    if (PHASE_TWO_PULSE) begin
      interrupt_control_d[TSI_BIT_T1_F:TSI_BIT_USB_F] = interrupt_control_d[TSI_BIT_T1_F:TSI_BIT_USB_F] | latched_q | hw_set;
      latched_d = 3'h0;
    end
    ep_d = ep_d | USB_EVENTS.ep_access;
    if (USB_EVENTS.suspend) begin
      link_d[TSI_BIT_SUSPEND] = 1'b1;
    end
    if (USB_EVENTS.resume) begin
      link_d[TSI_BIT_RESUME] = 1'b1;
    end
    // flags set at halt do not wake
    if (HALT_ENTER) begin
      halt_block_d = interrupt_control_q[TSI_BIT_T1_F:TSI_BIT_USB_F];
    end else if (!HALTED) begin
      halt_block_d = 3'h0;
    end
    if (HALTED && |(hw_set & ~halt_block_q)) begin
      wake_d = 1'b1;
    end
    pending = interrupt_control_q[TSI_BIT_T1_F:TSI_BIT_USB_F] & interrupt_control_q[TSI_BIT_T1_EN:TSI_BIT_USB_EN];
    // call accepted: core pushes pc only and branches
    if (call_q.req && CALL_TAKEN) begin
      call_d.req = 1'b0;
      interrupt_control_d[TSI_BIT_MASTER] = 1'b0;
      // an event landing on this pulse survives the clear
      case (call_q.source)
        2'h1: interrupt_control_d[TSI_BIT_USB_F] = PHASE_TWO_PULSE && (latched_q[0] || hw_set[0]);
        2'h2: interrupt_control_d[TSI_BIT_T0_F] = PHASE_TWO_PULSE && (latched_q[1] || hw_set[1]);
        2'h3: interrupt_control_d[TSI_BIT_T1_F] = PHASE_TWO_PULSE && (latched_q[2] || hw_set[2]);
        default: interrupt_control_d = interrupt_control_d;
      endcase
    // only while master set; stack not full
    end else if (!call_q.req && PHASE_TWO_PULSE && interrupt_control_q[TSI_BIT_MASTER] && !STACK_FULL
                 && !HALTED && |pending) begin
      call_d.req = 1'b1;
      if (pending[0]) begin
        call_d.vector = TSI_VEC_USB;
        call_d.source = 2'h1;
      end else if (pending[1]) begin
        call_d.vector = TSI_VEC_T0;
        call_d.source = 2'h2;
      end else begin
        call_d.vector = TSI_VEC_T1;
        call_d.source = 2'h3;
      end
    // withdraw if stack filled or master cleared meanwhile
    end else if (call_q.req && (STACK_FULL || !interrupt_control_q[TSI_BIT_MASTER])) begin
      call_d.req = 1'b0;
    end
    interrupt_control_d[7] = 1'b0;
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      addr_q <= 12'h000;
      rdata_q <= 32'h00000000;
      interrupt_control_q <= TSI_INTERRUPT_CONTROL_RESET;
      ep_q <= 3'h0;
      link_q <= 8'h00;
      latched_q <= 3'h0;
      halt_block_q <= 3'h0;
      call_q <= '0;
      wake_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      interrupt_control_q <= interrupt_control_d;
      ep_q <= ep_d;
      link_q <= link_d;
      latched_q <= latched_d;
      halt_block_q <= halt_block_d;
      call_q <= call_d;
      wake_q <= wake_d;
    end
  end

  // zero wait states keeps the slave simple
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;
  assign CALL_REQ = call_q;
  assign WAKE_UP = wake_q;

endmodule : tsi_irq_unit

//--- dv/tsi_irq_unit_monitor.sv
// checker of the interrupt unit call and wake ports
`timescale 1ns/1ps
module tsi_irq_unit_monitor
  import tsi_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PHASE_TWO_PULSE,
  input wire logic STACK_FULL,
  input wire logic HALTED,
  input wire logic CALL_TAKEN,
  input wire tsi_call_type CALL_REQ,
  input wire logic WAKE_UP
);
  default clocking mcb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_take; CALL_REQ.req && CALL_TAKEN; endsequence
  sequence s_rise; $rose(CALL_REQ.req); endsequence
  property p_one; s_take |=> !CALL_REQ.req [*2]; endproperty
  property p_full; s_rise |-> !$past(STACK_FULL); endproperty
  property p_phase; s_rise |-> $past(PHASE_TWO_PULSE); endproperty
  property p_src; CALL_REQ.req |-> CALL_REQ.source != 2'h0; endproperty
  property p_usb; CALL_REQ.req && CALL_REQ.source == 2'h1 |-> CALL_REQ.vector == TSI_VEC_USB; endproperty
  property p_t0; CALL_REQ.req && CALL_REQ.source == 2'h2 |-> CALL_REQ.vector == TSI_VEC_T0; endproperty
  property p_t1; CALL_REQ.req && CALL_REQ.source == 2'h3 |-> CALL_REQ.vector == TSI_VEC_T1; endproperty
  property p_wake; WAKE_UP |-> $past(HALTED); endproperty
  a_one: assert property (p_one) else $error("request after take");
  a_full: assert property (p_full) else $error("request on full stack");
  a_phase: assert property (p_phase) else $error("request off phase");
  a_src: assert property (p_src) else $error("request without source");
  a_usb: assert property (p_usb) else $error("usb vector");
  a_t0: assert property (p_t0) else $error("timer0 vector");
  a_t1: assert property (p_t1) else $error("timer1 vector");
  a_wake: assert property (p_wake) else $error("wake while running");
endmodule : tsi_irq_unit_monitor
bind tsi_irq_unit tsi_irq_unit_monitor u_mon (.REF_CLK, .RST_N, .PHASE_TWO_PULSE, .STACK_FULL,
  .HALTED, .CALL_TAKEN, .CALL_REQ, .WAKE_UP);

//--- dv/tsi_core_model.sv
// core stack model answering vectored calls
`timescale 1ns/1ps
module tsi_core_model
  import tsi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire tsi_call_type call,
  input wire logic slow,
  input wire logic pop,
  output logic taken,
  output logic full
);
  logic [3:0] depth_q;
  logic [1:0] wait_q;
  assign full = depth_q == TSI_STACK_DEPTH;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      depth_q <= 4'h0;
      wait_q <= 2'h0;
      taken <= 1'b0;
    end else begin
      taken <= 1'b0;
      if (pop && depth_q != 4'h0) depth_q <= depth_q - 4'h1;
      if (call.req && !taken && !full) begin
        wait_q <= wait_q + 2'h1;
        if (!slow || wait_q == 2'h3) begin
          taken <= 1'b1;
          depth_q <= depth_q + 4'h1;
          wait_q <= 2'h0;
        end
      end
    end
  end
endmodule : tsi_core_model

//--- dv/tsi_irq_unit_tb.sv
// self-checking bench of the interrupt unit
`timescale 1ns/1ps
module tsi_irq_unit_tb
  import tsi_pkg::*;
;
  typedef struct packed {logic [7:0] ev; logic [11:0] vec; logic [11:0] adr; logic [7:0] val;} tsi_row_type;
  logic clk = 1'b0, rst_n = 1'b0, p2 = 1'b0, t0 = 1'b0, t1 = 1'b0, return_from_interrupt = 1'b0, hen = 1'b0;
  logic hlt = 1'b0, hold = 1'b0, slow = 1'b0, hw = 1'b0, taken, full, rdy, wake, got, resp;
  logic [1:0] ht = 2'h0;
  logic [31:0] ha = '0, hwd = '0, hrd;
  logic [7:0] q;
  logic [2:0] ph = 3'h0;
  tsi_usb_ev_type usb = '0;
  tsi_call_type call;
  int bad_count = 0, num_checks = 0, cyc = 0;
  tsi_row_type rows [6] = '{'{8'h01, TSI_VEC_USB, TSI_ADDR_EPST, 8'h01},
    '{8'h20, TSI_VEC_USB, TSI_ADDR_LINK, 8'h01}, '{8'h10, TSI_VEC_USB, TSI_ADDR_LINK, 8'h09},
    '{8'h08, TSI_VEC_USB, TSI_ADDR_INTERRUPT_CONTROL, 8'h0e}, '{8'h40, TSI_VEC_T0, TSI_ADDR_INTERRUPT_CONTROL, 8'h0e},
    '{8'h80, TSI_VEC_T1, TSI_ADDR_INTERRUPT_CONTROL, 8'h0e}};
  tsi_irq_unit dut (.REF_CLK(clk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(ha), .HTRANS(ht), .HWRITE(hw),
    .HSIZE(3'h2), .HWDATA(hwd), .HREADY(rdy), .HRDATA(hrd), .HREADYOUT(rdy), .HRESP(resp),
    .PHASE_TWO_PULSE(p2), .TIMER0_OVERFLOW(t0), .TIMER1_OVERFLOW(t1), .USB_EVENTS(usb),
    .STACK_FULL(full | hold), .RETURN_FROM_INTERRUPT(return_from_interrupt), .HALT_ENTER(hen), .HALTED(hlt),
    .CALL_TAKEN(taken), .CALL_REQ(call), .WAKE_UP(wake));
  tsi_core_model core (.clk(clk), .rst_n(rst_n), .call(call), .slow(slow), .pop(return_from_interrupt), .taken(taken),
    .full(full));
  initial forever #4 clk = ~clk;
  // phase pulse every eight cycles; the timeout lives here too
  always @(posedge clk) begin
    ph <= ph + 3'h1;
    p2 <= ph == 3'h3;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic cmp_val(input string n, input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_val
  task automatic cmp_bit(input string n, input logic e);
    num_checks++;
    if (got !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", n, e, got);
    end
  endtask : cmp_bit
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    ht <= 2'h2;
    ha <= {20'h0, a};
    hw <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    ht <= 2'h0;
    hwd <= {24'h0, d};
    do @(posedge clk); while (rdy !== 1'b1);
    q = hrd[7:0];
  endtask : bus
  task automatic wait_for(input logic wk);
    got = 1'b0;
    repeat (40) begin
      @(posedge clk);
      if ((wk ? wake : call.req) === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask : wait_for
  task automatic fire(input logic [7:0] c);
    @(posedge clk) {t1, t0, usb} <= c;
    @(posedge clk) {t1, t0, usb} <= '0;
  endtask : fire
  task automatic serve(input logic [1:0] s);
    wait_for(1'b0);
    cmp_bit("req", 1'b1);
    cmp_val("source", s, call.source);
    repeat (10) @(posedge clk) if (call.req !== 1'b1) break;
  endtask : serve
  task automatic ret;
    @(posedge clk) return_from_interrupt <= 1'b1;
    @(posedge clk) return_from_interrupt <= 1'b0;
  endtask : ret
  task automatic halt(input logic h);
    @(posedge clk) {hlt, hen} <= {h, h};
    @(posedge clk) hen <= 1'b0;
  endtask : halt
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, TSI_ADDR_INTERRUPT_CONTROL, 8'h00);
    cmp_val("reset", TSI_INTERRUPT_CONTROL_RESET, q);
    bus(1'b1, TSI_ADDR_INTERRUPT_CONTROL, 8'hf0);
    bus(1'b0, TSI_ADDR_INTERRUPT_CONTROL, 8'h00);
    cmp_val("interrupt_control", 8'h70, q);
    bus(1'b1, TSI_ADDR_INTERRUPT_CONTROL, 8'h00);
    bus(1'b0, 12'h0f0, 8'h00);
    cmp_val("unmapped", 8'h00, q);
    cmp_val("hresp", 12'h000, {11'h000, resp});
    $display("register test done");
    foreach (rows[i]) begin
      slow <= i[0];
      bus(1'b1, TSI_ADDR_INTERRUPT_CONTROL, 8'h0f);
      fire(rows[i].ev);
      wait_for(1'b0);
      cmp_val("vector", rows[i].vec, call.vector);
      serve(rows[i].vec[3:2]);
      bus(1'b0, rows[i].adr, 8'h00);
      cmp_val("status", rows[i].val, q);
      ret();
    end
    $display("table test done");
    bus(1'b1, TSI_ADDR_INTERRUPT_CONTROL, 8'h04);
    fire(8'h40);
    wait_for(1'b0);
    cmp_bit("masked", 1'b0);
    bus(1'b0, TSI_ADDR_INTERRUPT_CONTROL, 8'h00);
    cmp_val("flag", 8'h24, q);
    bus(1'b1, TSI_ADDR_INTERRUPT_CONTROL, 8'h25);
    serve(2'h2);
    ret();
    hold <= 1'b1;
    bus(1'b1, TSI_ADDR_INTERRUPT_CONTROL, 8'h09);
    fire(8'h80);
    wait_for(1'b0);
    cmp_bit("full", 1'b0);
    hold <= 1'b0;
    serve(2'h3);
    ret();
    bus(1'b1, TSI_ADDR_INTERRUPT_CONTROL, 8'h0f);
    fire(8'hc1);
    for (int k = 1; k < 4; k++) begin
      serve(k[1:0]);
      ret();
    end
    $display("priority test done");
    bus(1'b1, TSI_ADDR_INTERRUPT_CONTROL, 8'h04);
    halt(1'b1);
    fire(8'h40);
    wait_for(1'b1);
    cmp_bit("wake", 1'b1);
    halt(1'b0);
    // let the phase pulse land the flag before halting again
    repeat (10) @(posedge clk);
    bus(1'b0, TSI_ADDR_INTERRUPT_CONTROL, 8'h00);
    cmp_val("halt flag", 8'h24, q);
    halt(1'b1);
    fire(8'h40);
    wait_for(1'b1);
    cmp_bit("blocked", 1'b0);
    halt(1'b0);
    $display("halt test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, TSI_ADDR_INTERRUPT_CONTROL, 8'h00);
    cmp_val("reset again", TSI_INTERRUPT_CONTROL_RESET, q);
    $display("reset test done");
    stop_test();
  end
endmodule : tsi_irq_unit_tb
